// >>> tars_supervisor.sv
// Trip supervisor: trip entry, resets, counted auto-reset, healthy flag and status word.
// Assumes parameter writes arrive as one-cycle strobes with data, synchronous to the clock.
`timescale 1ns/10ps
module tars_supervisor #(
    parameter int unsigned TICK_CYCLES = tars_pkg::TICK_CYCLES,
    parameter int unsigned CLEAR_TICKS = tars_pkg::CLEAR_TICKS
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_ext_trip_input,
    input wire logic i_braking,
    input wire logic [11:0] i_overload_time,
    input wire logic [7:0] i_recovery_period,
    input wire logic i_fault_valid,
    input wire logic [7:0] i_fault_code,
    input wire logic i_motor_stopped,
    input wire logic [12:0] i_drive_flags,
    input wire logic i_wr_ext_trip,
    input wire logic i_wr_reset_ctrl,
    input wire logic i_wr_attempts,
    input wire logic i_wr_delay,
    input wire logic i_wr_hold,
    input wire logic i_wr_stop_minor,
    input wire logic i_wr_user_trip,
    input wire logic [7:0] i_wr_data,
    output logic o_tripped,
    output logic [7:0] o_trip_code,
    output logic o_user_trip_logged,
    output logic o_stop_request,
    output logic o_drive_reset,
    output logic o_healthy,
    output logic [2:0] o_reset_count,
    output logic [6:0] o_resistor_percent,
    output logic [14:0] o_status_word,
    output logic o_external_trip_flag,
    output logic o_reset_ctrl,
    output logic [7:0] o_user_trip_value,
    output logic [2:0] o_attempt_limit,
    output logic [7:0] o_delay_tenths,
    output logic o_hold_healthy,
    output logic o_stop_minor
);
    typedef enum logic [1:0] {TARS_RUN, TARS_STOPPING, TARS_TRIPPED} tars_state_e;

    function automatic logic is_minor(input logic [7:0] code);
        is_minor = (code == tars_pkg::TRIP_LOOP_LOSS) || (code == tars_pkg::TRIP_MEM_SAVE) ||
                   (code == tars_pkg::TRIP_OVERLOAD) || (code == tars_pkg::TRIP_PHASE_LOSS);
    endfunction

    function automatic logic [7:0] min_delay(input logic [7:0] code, input logic [7:0] cfg);
        if (code == tars_pkg::TRIP_OVERCURRENT && cfg < tars_pkg::OVERCURRENT_MIN_DELAY) begin
            min_delay = tars_pkg::OVERCURRENT_MIN_DELAY;
        end else begin
            min_delay = cfg;
        end
    endfunction

    tars_pkg::tars_cfg_s cfg;
    tars_pkg::tars_trip_s pend;
    tars_pkg::tars_trip_s stop_trip;
    tars_state_e state;
    logic tick;
    logic res_trip;
    logic [6:0] res_pct;
    logic ext_flag;
    logic reset_ctrl;
    logic [7:0] user_trip;
    logic [7:0] prev_code;
    logic [2:0] count;
    logic [7:0] delay_left;
    logic auto_armed;
    logic [15:0] clear_ticks;
    logic [7:0] trip_code;
    logic healthy;
    logic drive_reset;
    logic user_logged;

    tars_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .o_tick(tick)
    );

    tars_resistor_model u_resistor (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_tick(tick),
        .i_braking(i_braking),
        .i_overload_time(i_overload_time),
        .i_recovery_period(i_recovery_period),
        .o_trip(res_trip),
        .o_percent(res_pct)
    );

    // Serial writes to the external flag strobe are deliberately not decoded.
    wire ext_write_ignored = i_wr_ext_trip;
    wire ctrl_rise = i_wr_reset_ctrl && i_wr_data[0] && !reset_ctrl;
    wire user_in_range = (i_wr_data <= tars_pkg::USER_TRIP_MAX);
    wire user_reset = i_wr_user_trip && (i_wr_data == tars_pkg::USER_RESET_CODE);
    wire user_trip_hit = i_wr_user_trip && user_in_range && (i_wr_data != tars_pkg::TRIP_NONE) &&
                         (i_wr_data != tars_pkg::USER_RESET_CODE);
    wire manual_reset = ctrl_rise || user_reset;

    // Fixed priority: external flag, then resistor overload, then user trips, then drive faults.
    wire ext_hit = ext_flag && !ext_write_ignored || ext_flag;
    wire [7:0] new_code = ext_hit ? tars_pkg::TRIP_EXTERNAL :
                          res_trip ? tars_pkg::TRIP_RESISTOR :
                          user_trip_hit ? i_wr_data : i_fault_code;
    wire new_trip = ext_hit || res_trip || user_trip_hit || i_fault_valid;
    wire same_code = (new_code == prev_code);
    wire [2:0] next_count = same_code ? count + 3'h1 : 3'h0;
    // Attempts remain only while the count taken before this trip is below the limit.
    wire [2:0] count_before = same_code ? count : 3'h0;
    wire will_auto = (cfg.attempt_limit != 3'h0) &&
                     (count_before < cfg.attempt_limit) &&
                     (new_code != tars_pkg::TRIP_EXTERNAL);
    wire stop_first = cfg.stop_minor && is_minor(new_code) && !i_motor_stopped;
    wire [7:0] next_delay = min_delay(new_code, cfg.delay_tenths);
    wire [7:0] lim_delay = (i_wr_data > tars_pkg::DELAY_MAX) ? tars_pkg::DELAY_MAX : i_wr_data;
    wire [2:0] lim_attempts = (i_wr_data[2:0] > tars_pkg::ATTEMPT_MAX || i_wr_data[7:3] != 5'h00) ?
                              tars_pkg::ATTEMPT_MAX : i_wr_data[2:0];
    wire timer_done = auto_armed && (delay_left == 8'h00);
    wire [14:0] next_status = {i_drive_flags, state == TARS_TRIPPED, healthy};

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cfg <= '{3'h0, tars_pkg::DELAY_RESET, 1'b0, 1'b0};
            reset_ctrl <= 1'b0;
            user_trip <= 8'h00;
        end else begin
            if (i_wr_attempts) begin
                cfg.attempt_limit <= lim_attempts;
            end
            if (i_wr_delay) begin
                cfg.delay_tenths <= lim_delay;
            end
            if (i_wr_hold) begin
                cfg.hold_healthy <= i_wr_data[0];
            end
            if (i_wr_stop_minor) begin
                cfg.stop_minor <= i_wr_data[0];
            end
            if (i_wr_reset_ctrl) begin
                reset_ctrl <= i_wr_data[0];
            end
            if (i_wr_user_trip && user_in_range) begin
                user_trip <= i_wr_data;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ext_flag <= 1'b0;
        end else begin
            ext_flag <= i_ext_trip_input;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state <= TARS_RUN;
            pend <= '0;
            stop_trip <= '0;
            prev_code <= tars_pkg::TRIP_NONE;
            count <= 3'h0;
            delay_left <= 8'h00;
            auto_armed <= 1'b0;
            trip_code <= tars_pkg::TRIP_NONE;
            healthy <= 1'b1;
            drive_reset <= 1'b0;
            user_logged <= 1'b0;
        end else begin
            // A written reset pulses in any state, so a rising control bit is seen while running.
            drive_reset <= manual_reset;
            unique case (state)
                TARS_RUN: begin
                    if (new_trip && stop_first) begin
                        state <= TARS_STOPPING;
                        stop_trip <= '{1'b1, new_code};
                    end else if (new_trip) begin
                        state <= TARS_TRIPPED;
                        trip_code <= new_code;
                        prev_code <= new_code;
                        count <= will_auto ? next_count : count_before;
                        auto_armed <= will_auto;
                        delay_left <= next_delay;
                        healthy <= cfg.hold_healthy && will_auto;
                        user_logged <= user_trip_hit && i_wr_data >= tars_pkg::USER_TRIP_LOW &&
                                       i_wr_data <= tars_pkg::USER_TRIP_HIGH;
                    end
                end
                TARS_STOPPING: begin
                    if (i_motor_stopped) begin
                        state <= TARS_TRIPPED;
                        trip_code <= stop_trip.code;
                        prev_code <= stop_trip.code;
                        auto_armed <= will_auto;
                        delay_left <= next_delay;
                        count <= will_auto ? next_count : count_before;
                        healthy <= cfg.hold_healthy && will_auto;
                        stop_trip <= '0;
                    end
                end
                TARS_TRIPPED: begin
                    if (manual_reset || timer_done) begin
                        state <= TARS_RUN;
                        drive_reset <= 1'b1;
                        auto_armed <= 1'b0;
                        trip_code <= tars_pkg::TRIP_NONE;
                        healthy <= 1'b1;
                        user_logged <= 1'b0;
                    end else if (auto_armed && tick && delay_left != 8'h00) begin
                        delay_left <= delay_left - 8'h01;
                    end
                end
            endcase
            if (state == TARS_RUN && !new_trip && clear_ticks == 16'(CLEAR_TICKS)) begin
                count <= 3'h0;
            end
            pend <= '{new_trip, new_code};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || state != TARS_RUN || new_trip) begin
            clear_ticks <= 16'h0000;
        end else if (tick && clear_ticks != 16'(CLEAR_TICKS)) begin
            clear_ticks <= clear_ticks + 16'h0001;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_tripped <= 1'b0;
            o_trip_code <= 8'h00;
            o_user_trip_logged <= 1'b0;
            o_stop_request <= 1'b0;
            o_drive_reset <= 1'b0;
            o_healthy <= 1'b0;
            o_reset_count <= 3'h0;
            o_resistor_percent <= 7'h00;
            o_status_word <= 15'h0000;
            o_external_trip_flag <= 1'b0;
            o_reset_ctrl <= 1'b0;
            o_user_trip_value <= 8'h00;
            o_attempt_limit <= 3'h0;
            o_delay_tenths <= 8'h00;
            o_hold_healthy <= 1'b0;
            o_stop_minor <= 1'b0;
        end else begin
            o_tripped <= (state == TARS_TRIPPED);
            o_trip_code <= trip_code;
            o_user_trip_logged <= user_logged;
            o_stop_request <= (state == TARS_STOPPING);
            o_drive_reset <= drive_reset;
            o_healthy <= healthy;
            o_reset_count <= count;
            o_resistor_percent <= res_pct;
            o_status_word <= next_status;
            o_external_trip_flag <= ext_flag;
            o_reset_ctrl <= reset_ctrl;
            o_user_trip_value <= user_trip;
            o_attempt_limit <= cfg.attempt_limit;
            o_delay_tenths <= cfg.delay_tenths;
            o_hold_healthy <= cfg.hold_healthy;
            o_stop_minor <= cfg.stop_minor;
        end
    end
endmodule

// >>> tars_pkg.sv
// Package for the trip and auto-reset supervisor: trip codes, field layouts and timing.
// Assumes a 10 MHz system clock; every consumer refers to names as tars_pkg::name.
package tars_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam real TICK_TIME_S = 0.1;
    localparam int unsigned TICK_CYCLES = int'(TICK_TIME_S * real'(CLK_HZ));
    localparam real CLEAR_TIME_MIN = 2.0;
    localparam int unsigned CLEAR_TICKS = int'(CLEAR_TIME_MIN * 60.0 / TICK_TIME_S);
    localparam logic [7:0] DELAY_RESET = 8'h0a;
    localparam logic [7:0] DELAY_MAX = 8'hfa;
    localparam logic [2:0] ATTEMPT_MAX = 3'h5;
    localparam logic [7:0] TRIP_NONE = 8'h00;
    localparam logic [7:0] TRIP_OVERCURRENT = 8'h03;
    localparam logic [7:0] TRIP_EXTERNAL = 8'h06;
    localparam logic [7:0] TRIP_RESISTOR = 8'h13;
    localparam logic [7:0] TRIP_LOOP_LOSS = 8'h1c;
    localparam logic [7:0] TRIP_MEM_SAVE = 8'h1f;
    localparam logic [7:0] TRIP_OVERLOAD = 8'h1a;
    localparam logic [7:0] TRIP_PHASE_LOSS = 8'h20;
    localparam logic [7:0] USER_TRIP_LOW = 8'h28;
    localparam logic [7:0] USER_TRIP_HIGH = 8'h63;
    localparam logic [7:0] USER_RESET_CODE = 8'h64;
    localparam logic [7:0] USER_TRIP_MAX = 8'hc8;
    localparam logic [7:0] OVERCURRENT_MIN_DELAY = 8'h0a;
    localparam logic [15:0] ACC_FULL = 16'hffff;
    localparam logic [6:0] PERCENT_FULL = 7'h64;
    localparam int unsigned STATUS_W = 15;
    localparam int unsigned HEALTHY_BIT = 0;
    localparam int unsigned TRIPPED_BIT = 1;

    typedef struct packed {
        logic [2:0] attempt_limit;
        logic [7:0] delay_tenths;
        logic hold_healthy;
        logic stop_minor;
    } tars_cfg_s;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } tars_trip_s;
endpackage

// >>> tars_tick.sv
// Tick generator that divides the system clock into one pulse per tenth of a second.
// Assumes a free running system clock and a synchronous high reset.
`timescale 1ns/10ps
module tars_tick #(
    parameter int unsigned CYCLES = tars_pkg::TICK_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    output logic o_tick
);
    logic [23:0] count;
    wire last = (count == 24'(CYCLES - 1));

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            count <= 24'h000000;
            o_tick <= 1'b0;
        end else begin
            count <= last ? 24'h000000 : count + 24'h000001;
            o_tick <= last;
        end
    end
endmodule

// >>> tars_resistor_model.sv
// Braking resistor thermal accumulator with rise from braking and decay toward ambient.
// Assumes the braking indication is a level synchronous to the system clock.
`timescale 1ns/10ps
module tars_resistor_model (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_tick,
    input wire logic i_braking,
    input wire logic [11:0] i_overload_time,
    input wire logic [7:0] i_recovery_period,
    output logic o_trip,
    output logic [6:0] o_percent
);
    logic [15:0] acc;
    // Rise per tick is full scale over the short-overload time in tenths; a zero time rises at once.
    wire [15:0] rise = (i_overload_time == 12'h000) ? tars_pkg::ACC_FULL :
                       16'(32'(tars_pkg::ACC_FULL) / 32'(i_overload_time));
    // Decay is proportional to the temperature above ambient, slower for a longer recovery.
    wire [15:0] decay = 16'(32'(acc) / (32'(i_recovery_period) * 32'd600 + 32'd1));
    wire [16:0] sum = {1'b0, acc} + {1'b0, rise};
    wire enabled = (i_recovery_period != 8'h00);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || !enabled) begin
            acc <= 16'h0000;
            o_trip <= 1'b0;
            o_percent <= 7'h00;
        end else begin
            if (i_tick) begin
                if (i_braking) begin
                    acc <= sum[16] ? tars_pkg::ACC_FULL : sum[15:0];
                end else begin
                    acc <= acc - ((decay == 16'h0000 && acc != 16'h0000) ? 16'h0001 : decay);
                end
            end
            o_trip <= (acc == tars_pkg::ACC_FULL);
            o_percent <= 7'((32'(acc) * 32'(tars_pkg::PERCENT_FULL)) / 32'hffff);
        end
    end
endmodule

// >>> tars_host_model.sv
// Serial master and digital input model facing the supervisor parameter port.
// Assumes writes launch at the falling edge and are taken at the next rising edge.
`timescale 1ns/10ps
module tars_host_model (
    input wire logic i_clk_sys,
    output logic o_ext_trip_input,
    output logic [6:0] o_wr_sel,
    output logic [7:0] o_wr_data
);
    initial begin
        o_ext_trip_input = 1'b0;
        o_wr_sel = 7'h00;
        o_wr_data = 8'h00;
    end
    // Data flips when idle, so a design that takes it without a strobe is caught.
    task automatic write(input int unsigned s, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_wr_sel = 7'h01 << s;
        o_wr_data = d;
        @(negedge i_clk_sys);
        o_wr_sel = 7'h00;
        o_wr_data = ~d;
    endtask
    task automatic reset_drive();
        write(6, tars_pkg::USER_RESET_CODE);
    endtask
    task automatic set_input(input logic v);
        @(negedge i_clk_sys);
        o_ext_trip_input = v;
    endtask
endmodule

// >>> tars_supervisor_sva.sv
// Checker for the supervisor, watching the top module ports only.
// Assumes the bench keeps other trip causes quiet around each watched write.
`timescale 1ns/10ps
module tars_supervisor_chk #(
    parameter int unsigned TICK_CYCLES = 10,
    parameter int unsigned CLEAR_TICKS = 20
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_ext_trip_input,
    input wire logic i_wr_ext_trip,
    input wire logic i_wr_reset_ctrl,
    input wire logic i_wr_attempts,
    input wire logic i_wr_delay,
    input wire logic i_wr_user_trip,
    input wire logic [7:0] i_wr_data,
    input wire logic o_tripped,
    input wire logic [7:0] o_trip_code,
    input wire logic o_drive_reset,
    input wire logic o_healthy,
    input wire logic o_external_trip_flag,
    input wire logic o_reset_ctrl,
    input wire logic [2:0] o_attempt_limit,
    input wire logic [7:0] o_delay_tenths,
    input wire logic o_hold_healthy
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    sequence quiet;
        !o_tripped && !i_ext_trip_input && !o_external_trip_flag;
    endsequence
    sequence user_wr(logic [7:0] v);
        i_wr_user_trip && i_wr_data == v;
    endsequence
    user_trip_a: assert property ((quiet ##0 (i_wr_user_trip && i_wr_data inside {[8'h28:8'h63]}))
        |-> ##2 (o_tripped && o_trip_code == $past(i_wr_data, 2))) else $error("user trip");
    user_reset_a: assert property (user_wr(tars_pkg::USER_RESET_CODE) |-> ##2 o_drive_reset)
        else $error("user reset");
    reset_pulse_a: assert property (o_drive_reset |=> !o_drive_reset) else $error("pulse");
    ctrl_edge_a: assert property ((i_wr_reset_ctrl && i_wr_data[0] && !o_reset_ctrl
        && !$past(i_wr_reset_ctrl)) |-> ##2 o_drive_reset) else $error("ctrl edge");
    ext_ro_a: assert property ((i_wr_ext_trip && !i_ext_trip_input)
        |-> ##2 !o_external_trip_flag) else $error("ext write");
    ext_trip_a: assert property (($rose(i_ext_trip_input) && !o_tripped && $past(!o_tripped))
        |-> ##3 (o_tripped && o_trip_code == tars_pkg::TRIP_EXTERNAL)) else $error("ext trip");
    ext_latch_a: assert property ((o_tripped && o_trip_code == tars_pkg::TRIP_EXTERNAL
        && !i_wr_user_trip && !i_wr_reset_ctrl && !$past(i_wr_user_trip)
        && !$past(i_wr_reset_ctrl)) |=> o_tripped) else $error("ext");
    limit_sat_a: assert property ((i_wr_attempts && i_wr_data > 8'h05)
        |-> ##2 o_attempt_limit == tars_pkg::ATTEMPT_MAX) else $error("limit");
    delay_sat_a: assert property ((i_wr_delay && i_wr_data > tars_pkg::DELAY_MAX)
        |-> ##2 o_delay_tenths == tars_pkg::DELAY_MAX) else $error("delay");
    healthy_drop_a: assert property (($rose(o_tripped) && !o_hold_healthy) |-> !o_healthy)
        else $error("healthy");
endmodule
bind tars_supervisor tars_supervisor_chk #(.TICK_CYCLES(TICK_CYCLES), .CLEAR_TICKS(CLEAR_TICKS))
    u_chk (.*);

// >>> tb.sv
// Self-checking bench for the trip supervisor driven through the serial master model.
// Assumes shortened tick and clear counts so auto-reset timing fits a short run.
`timescale 1ns/10ps
module tb;
    localparam int unsigned TK = 10;
    localparam int unsigned CT = 20;
    logic i_clk_sys, i_sys_rst = 1'b1, i_braking = 1'b0, i_fault_valid = 1'b0;
    logic i_motor_stopped = 1'b0;
    logic [11:0] i_overload_time = 12'h000;
    logic [7:0] i_recovery_period = 8'h00, i_fault_code = 8'h00;
    logic [12:0] i_drive_flags = 13'h1555;
    wire i_ext_trip_input;
    wire [7:0] i_wr_data;
    wire [6:0] sel;
    logic o_tripped, o_user_trip_logged, o_stop_request, o_drive_reset, o_healthy;
    logic o_external_trip_flag, o_reset_ctrl, o_hold_healthy, o_stop_minor;
    logic [7:0] o_trip_code, o_user_trip_value, o_delay_tenths;
    logic [2:0] o_reset_count, o_attempt_limit;
    logic [6:0] o_resistor_percent;
    logic [14:0] o_status_word;
    int error_cnt = 0;
    int comparisons = 0;
    int c;
    tars_host_model u_host (.i_clk_sys, .o_ext_trip_input(i_ext_trip_input), .o_wr_sel(sel),
        .o_wr_data(i_wr_data));
    tars_supervisor #(.TICK_CYCLES(TK), .CLEAR_TICKS(CT)) dut (.*, .i_wr_ext_trip(sel[0]),
        .i_wr_reset_ctrl(sel[1]), .i_wr_attempts(sel[2]), .i_wr_delay(sel[3]),
        .i_wr_hold(sel[4]), .i_wr_stop_minor(sel[5]), .i_wr_user_trip(sel[6]));
    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    // Returns at the first falling edge after the write is visible at the outputs.
    task automatic wr(input int unsigned s, input logic [7:0] d);
        u_host.write(s, d);
        tick(1);
    endtask
    task automatic wait_rst(input int n);
        c = 0;
        while (o_drive_reset !== 1'b1 && c < n) begin
            tick(1);
            c++;
        end
    endtask
    task automatic man_rst();
        u_host.reset_drive();
        tick(1);
        chk(o_drive_reset === 1'b1 && o_tripped === 1'b0, "manual reset");
        tick(1);
    endtask
    task automatic s_defaults();
        chk(o_attempt_limit === 3'h0 && o_delay_tenths === tars_pkg::DELAY_RESET, "lim dly");
        chk(o_hold_healthy === 1'b0 && o_stop_minor === 1'b0 && o_reset_ctrl === 1'b0, "cfg");
        chk(o_status_word === {i_drive_flags, 2'b01}, "status");
    endtask
    task automatic s_ext();
        wr(0, 8'h01);
        chk(o_external_trip_flag === 1'b0, "ext write");
        wr(2, 8'h05);
        u_host.set_input(1'b1);
        tick(4);
        chk(o_tripped === 1'b1 && o_trip_code === tars_pkg::TRIP_EXTERNAL, "ext");
        chk(o_status_word[1:0] === 2'b10, "status trip");
        tick(TK * 15);
        chk(o_tripped === 1'b1, "ext auto");
        u_host.set_input(1'b0);
        man_rst();
    endtask
    task automatic s_ctrl();
        wr(1, 8'h01);
        chk(o_drive_reset === 1'b1 && o_reset_ctrl === 1'b1, "rise");
        wr(1, 8'h01);
        chk(o_drive_reset === 1'b0, "level");
        wr(1, 8'h00);
        wr(1, 8'h01);
        chk(o_drive_reset === 1'b1, "rise again");
    endtask
    task automatic s_user();
        logic [7:0] codes [2] = '{tars_pkg::USER_TRIP_LOW, tars_pkg::USER_TRIP_HIGH};
        wr(6, 8'hfa);
        chk(o_tripped === 1'b0, "over range");
        foreach (codes[i]) begin
            wr(6, codes[i]);
            chk(o_tripped === 1'b1 && o_trip_code === codes[i], "user code");
            chk(o_user_trip_logged === 1'b1, "user log");
            man_rst();
        end
    endtask
    task automatic s_auto();
        wr(2, 8'h07);
        chk(o_attempt_limit === tars_pkg::ATTEMPT_MAX, "limit sat");
        wr(3, 8'hff);
        chk(o_delay_tenths === tars_pkg::DELAY_MAX, "delay sat");
        wr(3, 8'h0a);
        wr(2, 8'h02);
        wr(4, 8'h01);
        // The first trip clears the count, so a limit of two grants three auto-resets.
        for (int k = 0; k < 4; k++) begin
            wr(6, 8'h32);
            chk(o_tripped === 1'b1 && o_healthy === (k < 3), "held healthy");
            wait_rst(300);
            if (k < 3) begin
                chk(c >= 8 * TK && c <= 12 * TK, "auto delay");
            end else begin
                chk(c == 300 && o_reset_count === 3'h2, "latched");
            end
            tick(1);
        end
        man_rst();
        tick(CT * TK + 50);
        chk(o_reset_count === 3'h0, "count clear");
        wr(2, 8'h00);
        wr(6, 8'h3c);
        wait_rst(300);
        chk(c == 300, "no auto");
        man_rst();
    endtask
    task automatic s_minor();
        wr(5, 8'h01);
        i_fault_code = tars_pkg::TRIP_LOOP_LOSS;
        i_fault_valid = 1'b1;
        tick(4);
        chk(o_stop_request === 1'b1 && o_tripped === 1'b0, "stop first");
        i_motor_stopped = 1'b1;
        tick(4);
        chk(o_tripped === 1'b1 && o_trip_code === tars_pkg::TRIP_LOOP_LOSS, "minor");
        i_fault_valid = 1'b0;
        man_rst();
    endtask
    task automatic s_res();
        i_braking = 1'b1;
        tick(300);
        chk(o_tripped === 1'b0, "no protect");
        i_recovery_period = 8'h0a;
        c = 0;
        while (o_tripped !== 1'b1 && c < 5000) begin
            tick(1);
            c++;
        end
        tick(1);
        chk(o_trip_code === tars_pkg::TRIP_RESISTOR, "resistor");
        chk(o_resistor_percent === tars_pkg::PERCENT_FULL, "percent");
        i_braking = 1'b0;
        man_rst();
    endtask
    initial begin
        repeat (20) @(posedge i_clk_sys);
        tick(1);
        i_sys_rst = 1'b0;
        tick(3);
        s_defaults();
        s_ext();
        s_ctrl();
        s_user();
        s_auto();
        s_minor();
        s_res();
        conclude();
    end
    // The planned run is well under a third of this span.
    initial begin
        repeat (40000) @(posedge i_clk_sys);
        error_cnt++;
        $display("mismatch at %0t: watchdog", $time);
        conclude();
    end
endmodule
